// [rtl/ssram_pkg.sv]
// shared constants for the serial memory mode and bus port
package ssram_pkg;
  localparam logic [7:0] CMD_READ_MODE = 8'h05;
  localparam logic [7:0] CMD_WRITE_MODE = 8'h01;
  localparam logic [7:0] CMD_ENTER_DUAL = 8'h3B;
  localparam logic [7:0] CMD_ENTER_QUAD = 8'h38;
  localparam logic [7:0] CMD_REVERT_SINGLE = 8'hFF;
  localparam logic [1:0] ACC_BYTE = 2'h0;
  localparam logic [1:0] ACC_PAGE = 2'h2;
  localparam logic [1:0] ACC_SEQ = 2'h1;
  localparam logic [1:0] ACC_RSVD = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam logic [5:0] MODE_LOW_BITS = 6'h00;
  typedef enum logic [1:0] {SSRAM_SINGLE, SSRAM_DUAL, SSRAM_QUAD} ssram_bus_t;
  typedef enum {SSRAM_CMD, SSRAM_WDATA, SSRAM_RDATA, SSRAM_IGNORE} ssram_phase_t;
endpackage

// [rtl/ssram_sync.sv]
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module ssram_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [rtl/ssram_port.sv]
// serial port: command decode, mode register, pause and lane width control
`timescale 1ns/1ps
module ssram_port
  import ssram_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic in_lane0_i,
  output logic in_lane0_o,
  output logic in_lane0_oe,
  input wire logic out_lane1_i,
  output logic out_lane1_o,
  output logic out_lane1_oe,
  input wire logic data_lane2_i,
  output logic data_lane2_o,
  output logic data_lane2_oe,
  input wire logic pause_lane3_i,
  output logic pause_lane3_o,
  output logic pause_lane3_oe,
  output logic [1:0] access_mode,
  output ssram_pkg::ssram_bus_t bus_mode,
  output logic paused
);
  import ssram_pkg::*;

  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // select and pause idle high: carried inverted so a cleared flop reads idle
  logic [5:0] pins_s;
  ssram_sync #(.W(6)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({~sel_n, sclk, ~pause_lane3_i, data_lane2_i, out_lane1_i, in_lane0_i}),
    .q(pins_s)
  );
  logic sel_n_s, sclk_s, l3_s, l2_s, l1_s, l0_s;
  assign {sel_n_s, sclk_s, l3_s, l2_s, l1_s, l0_s} = pins_s ^ 6'h28;

  logic sclk_d;
  logic sel_n_d;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      sel_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      sel_n_d <= sel_n_s;
    end
  end
  logic rise, fall, selected;
  assign selected = !sel_n_s && !sel_n_d;
  assign rise = selected && sclk_s && !sclk_d;
  assign fall = selected && !sclk_s && sclk_d;

  ssram_bus_t bus;
  logic [1:0] mode_bits;
  ssram_phase_t phase;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [7:0] txreg;
  logic dummy;
  logic hold;
  logic armed;

  // pause only exists outside quad mode
  logic pause_req;
  assign pause_req = (bus != SSRAM_QUAD) && !l3_s;

  // pause takes effect or ends while clock low, else at next falling edge; deselect ends it at any clock level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= 1'b0;
    end else if (sel_n_s) begin
      hold <= 1'b0;
    end else if (pause_req != hold && (!sclk_s || fall)) begin
      hold <= pause_req;
    end
  end

  function automatic logic [3:0] step(input ssram_bus_t b);
    case (b)
      SSRAM_DUAL: step = 4'h2;
      SSRAM_QUAD: step = 4'h4;
      default: step = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input ssram_bus_t b, input logic [7:0] s,
                                          input logic [3:0] lanes);
    case (b)
      SSRAM_DUAL: shift_in = {s[5:0], lanes[1:0]};
      SSRAM_QUAD: shift_in = {s[3:0], lanes};
      default: shift_in = {s[6:0], lanes[0]};
    endcase
  endfunction

  logic [7:0] next_shreg;
  logic [3:0] next_bitcnt;
  logic byte_done;
  always_comb begin
    next_shreg = shift_in(bus, shreg, {l3_s, l2_s, l1_s, l0_s});
    next_bitcnt = bitcnt + step(bus);
    byte_done = (next_bitcnt == 4'h8);
  end

  logic active;
  assign active = selected && !hold;

  // receive side: command and data bytes on rising edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= SSRAM_CMD;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      bus <= SSRAM_SINGLE;
      mode_bits <= MODE_RESET;
    end else if (!selected) begin
      phase <= SSRAM_CMD;
      bitcnt <= 4'h0;
    end else if (active && rise && phase != SSRAM_IGNORE && phase != SSRAM_RDATA) begin
      shreg <= next_shreg;
      bitcnt <= byte_done ? 4'h0 : next_bitcnt;
      if (byte_done && phase == SSRAM_CMD) begin
        case (next_shreg)
          CMD_WRITE_MODE: phase <= SSRAM_WDATA;
          CMD_READ_MODE: phase <= SSRAM_RDATA;
          CMD_ENTER_DUAL: begin
            phase <= SSRAM_IGNORE;
            if (bus == SSRAM_SINGLE) bus <= SSRAM_DUAL;
          end
          CMD_ENTER_QUAD: begin
            phase <= SSRAM_IGNORE;
            if (bus == SSRAM_SINGLE) bus <= SSRAM_QUAD;
          end
          CMD_REVERT_SINGLE: begin
            phase <= SSRAM_IGNORE;
            bus <= SSRAM_SINGLE;
          end
          default: phase <= SSRAM_IGNORE;
        endcase
      end else if (byte_done && phase == SSRAM_WDATA) begin
        mode_bits <= next_shreg[MODE_HI:MODE_LO];
        phase <= SSRAM_IGNORE;
      end
    end
  end

  // transmit side: mode register after falling edges, dummy byte first in dual
  logic [3:0] txcnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txreg <= 8'h00;
      txcnt <= 4'h0;
      dummy <= 1'b0;
      armed <= 1'b0;
    end else if (!selected || phase != SSRAM_RDATA) begin
      txreg <= {mode_bits, MODE_LOW_BITS};
      txcnt <= 4'h0;
      dummy <= (bus == SSRAM_DUAL);
      armed <= 1'b0;
    end else if (active && fall) begin
      if (!armed) begin
        armed <= 1'b1;
        if (dummy) txreg <= 8'h00;
      end else if (txcnt + step(bus) == 4'h8) begin
        txcnt <= 4'h0;
        dummy <= 1'b0;
        txreg <= {mode_bits, MODE_LOW_BITS};
      end else begin
        txcnt <= txcnt + step(bus);
        case (bus)
          SSRAM_DUAL: txreg <= {txreg[5:0], 2'h0};
          SSRAM_QUAD: txreg <= {txreg[3:0], 4'h0};
          default: txreg <= {txreg[6:0], 1'b0};
        endcase
      end
    end
  end

  // output drivers registered from state; release with pause immediately
  logic drive;
  assign drive = armed && selected && phase == SSRAM_RDATA && !pause_req;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_lane0_o <= 1'b0;
      in_lane0_oe <= 1'b0;
      out_lane1_o <= 1'b0;
      out_lane1_oe <= 1'b0;
      data_lane2_o <= 1'b0;
      data_lane2_oe <= 1'b0;
      pause_lane3_o <= 1'b0;
      pause_lane3_oe <= 1'b0;
    end else begin
      case (bus)
        SSRAM_QUAD: begin
          {pause_lane3_o, data_lane2_o, out_lane1_o, in_lane0_o} <= txreg[7:4];
          {pause_lane3_oe, data_lane2_oe, out_lane1_oe, in_lane0_oe} <= {4{drive}};
        end
        SSRAM_DUAL: begin
          {out_lane1_o, in_lane0_o} <= txreg[7:6];
          {out_lane1_oe, in_lane0_oe} <= {2{drive}};
          {pause_lane3_o, data_lane2_o, pause_lane3_oe, data_lane2_oe} <= 4'h0;
        end
        default: begin
          out_lane1_o <= txreg[7];
          out_lane1_oe <= drive;
          {pause_lane3_o, data_lane2_o, in_lane0_o} <= 3'h0;
          {pause_lane3_oe, data_lane2_oe, in_lane0_oe} <= 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      access_mode <= MODE_RESET;
      bus_mode <= SSRAM_SINGLE;
      paused <= 1'b0;
    end else begin
      access_mode <= mode_bits;
      bus_mode <= bus;
      paused <= hold;
    end
  end

  chk_paused_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    hold && selected |=> $stable(shreg) && $stable(bitcnt))
    else $error("sequence moved while paused");
  chk_quad_no_pause: assert property (@(posedge clk) disable iff (!rst_n)
    bus == SSRAM_QUAD |-> !hold)
    else $error("pause active in quad mode");
  chk_desel_release: assert property (@(posedge clk) disable iff (!rst_n)
    sel_n_s ##1 sel_n_s |=> !out_lane1_oe && !in_lane0_oe)
    else $error("lane driven while deselected");
  chk_pause_release: assert property (@(posedge clk) disable iff (!rst_n)
    pause_req |=> !out_lane1_oe)
    else $error("output driven during pause");
  chk_low_bits_zero: assert property (@(posedge clk) disable iff (!rst_n)
    armed && txcnt >= 4'h2 |-> txreg[7:6] == 2'h0)
    else $error("mode low bits nonzero");
  chk_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
    active && rise && phase == SSRAM_WDATA && byte_done
    |=> {mode_bits, MODE_LOW_BITS} == ($past(next_shreg) & 8'hC0))
    else $error("mode write lost");
  chk_pause_wait: assert property (@(posedge clk) disable iff (!rst_n)
    !hold && pause_req && sclk_s && !fall && selected |=> !hold)
    else $error("pause entered with clock high");
  chk_enter_dual: assert property (@(posedge clk) disable iff (!rst_n)
    active && rise && phase == SSRAM_CMD && byte_done && bus == SSRAM_SINGLE
    && next_shreg == CMD_ENTER_DUAL |=> bus == SSRAM_DUAL)
    else $error("dual mode not entered");

  // multi-step checks share these fragments
  sequence s_cmd_byte;
    active && rise && phase == SSRAM_CMD && byte_done;
  endsequence
  sequence s_clk_high;
    selected && sclk_s && !fall;
  endsequence
  sequence s_frozen;
    hold && selected;
  endsequence

  chk_enter_quad: assert property (@(posedge clk) disable iff (!rst_n)
    s_cmd_byte ##0 (bus == SSRAM_SINGLE && next_shreg == CMD_ENTER_QUAD)
    |=> bus == SSRAM_QUAD)
    else $error("quad mode not entered");
  chk_revert_single: assert property (@(posedge clk) disable iff (!rst_n)
    s_cmd_byte ##0 (next_shreg == CMD_REVERT_SINGLE) |=> bus == SSRAM_SINGLE)
    else $error("revert to single lost");
  chk_read_start: assert property (@(posedge clk) disable iff (!rst_n)
    s_cmd_byte ##0 (next_shreg == CMD_READ_MODE) |=> phase == SSRAM_RDATA)
    else $error("read-mode not started");
  chk_write_arm: assert property (@(posedge clk) disable iff (!rst_n)
    s_cmd_byte ##0 (next_shreg == CMD_WRITE_MODE) |=> phase == SSRAM_WDATA)
    else $error("write-mode data phase not entered");
  chk_pause_enter: assert property (@(posedge clk) disable iff (!rst_n)
    selected && !hold && pause_req && !sclk_s |=> hold)
    else $error("pause not entered with clock low");
  chk_resume_wait: assert property (@(posedge clk) disable iff (!rst_n)
    s_clk_high ##0 (hold && !pause_req) |=> hold)
    else $error("resumed with clock high");
  chk_tx_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    s_frozen ##1 s_frozen |-> $stable(txreg) && $stable(txcnt))
    else $error("output shifted while paused");
  chk_desel_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !selected |=> phase == SSRAM_CMD && bitcnt == 4'h0)
    else $error("sequence kept after deselect");
  chk_dual_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    bus == SSRAM_DUAL |=> !data_lane2_oe && !pause_lane3_oe)
    else $error("pause pin driven in dual mode");
  chk_quad_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    bus == SSRAM_QUAD && drive |=> pause_lane3_oe && data_lane2_oe && in_lane0_oe)
    else $error("quad lanes not driven");
  chk_dual_dummy: assert property (@(posedge clk) disable iff (!rst_n)
    active && fall && phase == SSRAM_RDATA && !armed && bus == SSRAM_DUAL
    |=> txreg == 8'h00)
    else $error("dual read lacks dummy byte");
  chk_pause_resume: assert property (@(posedge clk) disable iff (!rst_n)
    selected && armed && phase == SSRAM_RDATA && !pause_req |=> out_lane1_oe)
    else $error("output not driven after pause");
  chk_reset_mode: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> mode_bits == MODE_RESET && bus == SSRAM_SINGLE)
    else $error("wrong mode after reset");
  chk_rise_shift: assert property (@(posedge clk) disable iff (!rst_n)
    active && rise && phase == SSRAM_CMD && bus == SSRAM_SINGLE
    |=> shreg[0] == $past(l0_s) && (shreg >> 1) == ($past(shreg) & 8'h7F))
    else $error("command bits not shifted msb first");
endmodule

// [tb/ssram_host.sv]
// behavioural host controller for the serial port
`timescale 1ns/1ps
module ssram_host (
  input wire logic clk,
  input wire logic [3:0] lanes,
  output logic sel_n,
  output logic sclk,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe
);
  // half serial period in clk cycles: 160 ns link period
  localparam int HALF = 20;
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    lane_o = 4'hF;
    lane_oe = 4'h8;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic sel(input logic v);
    tick(HALF);
    sel_n <= v;
    tick(HALF);
  endtask
  // w bits per clock; drv low releases the data lanes for a read
  task automatic shift(input int w, input logic [7:0] tx, input logic drv,
                       output logic [7:0] rx);
    logic [3:0] m;
    logic [3:0] d;
    m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    rx = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      d = 4'(tx >> (8 - w * (k + 1))) & m;
      lane_o <= (w == 4) ? d : d | 4'h8;
      lane_oe <= (drv ? m : 4'h0) | ((w == 4) ? 4'h0 : 4'h8);
      tick(HALF);
      sclk <= 1'b1;
      rx = (rx << w) | 8'((w == 1) ? 4'(lanes[1]) : lanes & m);
      tick(HALF);
      sclk <= 1'b0;
    end
  endtask
  // clock and input keep moving while paused, so a frozen port shows
  task automatic hold_pause(input int n);
    lane_o[3] <= 1'b0;
    tick(HALF);
    repeat (n) begin
      sclk <= ~sclk;
      lane_o[0] <= ~lane_o[0];
      tick(HALF);
    end
  endtask
  task automatic end_pause;
    lane_o[3] <= 1'b1;
    tick(HALF);
  endtask
endmodule

// [tb/tb.sv]
// testbench: mode register, pause and lane width scenarios
`timescale 1ns/1ps
module tb;
  import ssram_pkg::*;
  logic clk;
  logic arst_n;
  logic sel_n;
  logic sclk;
  logic [3:0] h_o;
  logic [3:0] h_oe;
  logic [3:0] d_o;
  logic [3:0] d_oe;
  logic [3:0] lanes;
  logic [1:0] access_mode;
  ssram_bus_t bus_mode;
  logic paused;
  logic [7:0] rx;
  logic [1:0] mv [3] = '{ACC_BYTE, ACC_PAGE, ACC_SEQ};
  int error_cnt = 0;
  int checks_done = 0;
  // released lanes float up through pull-ups
  assign lanes = (d_oe & d_o) | (h_oe & ~d_oe & h_o) | (~d_oe & ~h_oe);
  ssram_host host (.clk(clk), .lanes(lanes), .sel_n(sel_n), .sclk(sclk),
    .lane_o(h_o), .lane_oe(h_oe));
  ssram_port dut (.clk(clk), .arst_n(arst_n), .sel_n(sel_n), .sclk(sclk),
    .in_lane0_i(lanes[0]), .in_lane0_o(d_o[0]), .in_lane0_oe(d_oe[0]),
    .out_lane1_i(lanes[1]), .out_lane1_o(d_o[1]), .out_lane1_oe(d_oe[1]),
    .data_lane2_i(lanes[2]), .data_lane2_o(d_o[2]), .data_lane2_oe(d_oe[2]),
    .pause_lane3_i(lanes[3]), .pause_lane3_o(d_o[3]), .pause_lane3_oe(d_oe[3]),
    .access_mode(access_mode), .bus_mode(bus_mode), .paused(paused));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp_v(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bus(input ssram_bus_t got, input ssram_bus_t exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t bus mode %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic cmd(input int w, input logic [7:0] c);
    host.sel(1'b0);
    host.shift(w, c, 1'b1, rx);
    host.sel(1'b1);
  endtask
  task automatic rd_mode(input int w, input logic [7:0] exp);
    host.sel(1'b0);
    host.shift(w, CMD_READ_MODE, 1'b1, rx);
    if (w == 2) begin
      host.shift(w, 8'h00, 1'b0, rx);
      cmp_v(rx, 8'h00);
    end
    host.shift(w, 8'h00, 1'b0, rx);
    cmp_v(rx, exp);
    host.sel(1'b1);
    cmp_v({4'h0, d_oe}, 8'h00);
  endtask
  initial begin
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    cmp_v({6'h00, access_mode}, {6'h00, MODE_RESET});
    rd_mode(1, 8'h40);
    foreach (mv[i]) begin
      host.sel(1'b0);
      host.shift(1, CMD_WRITE_MODE, 1'b1, rx);
      host.shift(1, {mv[i], 6'h00}, 1'b1, rx);
      host.sel(1'b1);
      cmp_v({6'h00, access_mode}, {6'h00, mv[i]});
      rd_mode(1, {mv[i], MODE_LOW_BITS});
    end
    host.sel(1'b0);
    host.shift(1, CMD_READ_MODE, 1'b1, rx);
    host.hold_pause(4);
    cmp_v({6'h00, paused, d_oe[1]}, 8'h02);
    host.end_pause();
    cmp_v({6'h00, paused, d_oe[1]}, 8'h01);
    host.shift(1, 8'h00, 1'b0, rx);
    cmp_v(rx, 8'h40);
    host.sel(1'b1);
    cmd(1, CMD_ENTER_DUAL);
    cmp_bus(bus_mode, SSRAM_DUAL);
    rd_mode(2, 8'h40);
    cmd(2, CMD_REVERT_SINGLE);
    cmp_bus(bus_mode, SSRAM_SINGLE);
    cmd(1, CMD_ENTER_QUAD);
    cmp_bus(bus_mode, SSRAM_QUAD);
    cmd(4, CMD_ENTER_DUAL);
    cmp_bus(bus_mode, SSRAM_QUAD);
    rd_mode(4, 8'h40);
    cmd(4, CMD_REVERT_SINGLE);
    cmp_bus(bus_mode, SSRAM_SINGLE);
    rd_mode(1, 8'h40);
    stop_test();
  end
  // a hung sequence still reaches the verdict
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
